/* design/mcc_pkg.sv */
// Constants and types of the conversion control block
// Behaviour
// RULE1 - Config reads never disturb settings or conversion
// RULE2 - Config write halts conversion until transfer ends
// RULE3 - Fresh conversion with new settings after write
// RULE4 - Bit 15 soft reset, then self-clears
// RULE5 - Bits 14..12 enable channels one to three
// RULE6 - Bits 11..9 pick averaging 1 to 1024
// RULE7 - Bits 8..6 pick rail conversion time
// RULE8 - Bits 5..3 pick drop conversion time
// RULE9 - Bits 2..0 pick power-down, single or continuous
// RULE10 - Config at address zero, resets to 7127h
// RULE11 - Address one holds averaged channel-one drop
// RULE12 - Negative results twos complement, sign in 15
// RULE13 - Drop step 40 uV, full scale 7FF8h
// RULE14 - Data in bits 14..3, 2..0 read zero
// RULE15 - Address two holds channel-one rail, 8 mV step
// RULE16 - Result registers read-only, reset to zero
// RULE17 - Each register moves as two bytes
// RULE18 - Mode 011 single-shot drop and rail
// RULE19 - Single-shot converts once then waits for write
package mcc_pkg;
  localparam logic [7:0] ADDR_CFG = 8'h00;
  localparam logic [7:0] ADDR_DROP = 8'h01;
  localparam logic [7:0] ADDR_RAIL = 8'h02;
  localparam logic [15:0] CFG_RESET = 16'h7127;
  localparam logic [15:0] RESULT_RESET = 16'h0000;
  localparam int SOFT_RST_BIT = 15;
  localparam int CH_ONE_BIT = 14;
  localparam int CH_TWO_BIT = 13;
  localparam int CH_THREE_BIT = 12;
  localparam int AVG_LSB = 9;
  localparam int RAIL_CT_LSB = 6;
  localparam int DROP_CT_LSB = 3;
  localparam int OP_LSB = 0;
  localparam int OP_DROP_BIT = 0;
  localparam int OP_RAIL_BIT = 1;
  localparam int OP_CONT_BIT = 2;
  localparam int RES_LSB = 3;
  localparam int SMP_W = 13;
  localparam int ACC_W = 23;
  localparam int CNT_W = 21;
  localparam int CLK_PERIOD_NS = 5;
  localparam int unsigned CONV_TIME_NS [8] = '{140000, 204000, 332000, 588000,
    1100000, 2116000, 4156000, 8244000};
  localparam int unsigned CONV_CYC [8] = '{
    CONV_TIME_NS[0] / CLK_PERIOD_NS, CONV_TIME_NS[1] / CLK_PERIOD_NS,
    CONV_TIME_NS[2] / CLK_PERIOD_NS, CONV_TIME_NS[3] / CLK_PERIOD_NS,
    CONV_TIME_NS[4] / CLK_PERIOD_NS, CONV_TIME_NS[5] / CLK_PERIOD_NS,
    CONV_TIME_NS[6] / CLK_PERIOD_NS, CONV_TIME_NS[7] / CLK_PERIOD_NS};
  // log2 of 1, 4, 16, 64, 128, 256, 512, 1024
  localparam logic [3:0] AVG_SHIFT [8] = '{4'h0, 4'h2, 4'h4, 4'h6,
    4'h7, 4'h8, 4'h9, 4'ha};
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_HALT = 3'b010,
    ST_RUN = 3'b100
  } mcc_state_t;
endpackage

/* design/mcc_avg_if.sv */
// Link between sequencer and sample averager
`timescale 1ns/1ps
interface mcc_avg_if;
  import mcc_pkg::*;
  logic clear;
  logic add;
  logic signed [SMP_W-1:0] sample;
  logic [3:0] shift;
  logic signed [SMP_W-1:0] mean;
  modport ctrl (output clear, output add, output sample, output shift, input mean);
  modport avg (input clear, input add, input sample, input shift, output mean);
endinterface

/* design/mcc_averager.sv */
// Signed sample accumulator with power-of-two mean
`timescale 1ns/1ps
module mcc_averager
  import mcc_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Sequencer side
  mcc_avg_if.avg av
);
  logic signed [ACC_W-1:0] acc_reg;
  logic signed [ACC_W-1:0] acc_next;
  logic signed [ACC_W-1:0] sum;

  // Mean includes the sample being added, so the last add yields it
  always_comb begin
    sum = acc_reg + ACC_W'(av.sample);
    acc_next = acc_reg;
    if (av.clear) begin
      acc_next = '0;
    end else if (av.add) begin
      acc_next = sum;
    end
  end

  assign av.mean = SMP_W'(sum >>> av.shift); // RULE6

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      acc_reg <= '0;
    end else begin
      acc_reg <= acc_next;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  chk_clear_zero: assert property (av.clear |=> acc_reg == 0) // RULE6
    else $error("accumulator not cleared");
endmodule

/* design/mcc_timer.sv */
// Conversion time counter
`timescale 1ns/1ps
module mcc_timer
  import mcc_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Control
  input wire logic start,
  input wire logic abort,
  input wire logic [CNT_W-1:0] load,
  // Status
  output logic done
);
  logic busy_reg;
  logic busy_next;
  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] cnt_next;

  assign done = busy_reg && (cnt_reg == CNT_W'(1));

  always_comb begin
    busy_next = busy_reg;
    cnt_next = cnt_reg;
    if (abort) begin
      busy_next = 1'b0;
    end else if (start) begin
      busy_next = 1'b1;
      cnt_next = load;
    end else if (done) begin
      busy_next = 1'b0;
    end else if (busy_reg) begin
      cnt_next = cnt_reg - CNT_W'(1);
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      busy_reg <= 1'b0;
      cnt_reg <= '0;
    end else begin
      busy_reg <= busy_next;
      cnt_reg <= cnt_next;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  chk_timer_length: assert property ( // RULE7
    start && !abort && load == CNT_W'(4) |=> !done[*3] ##1 done)
    else $error("conversion time count wrong");
endmodule

/* design/mcc_monitor_core.sv */
// Configuration, sequencing and channel-one result registers
`timescale 1ns/1ps
module mcc_monitor_core
  import mcc_pkg::*;
#(
  parameter int unsigned CONV_CYC_P [8] = CONV_CYC
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Register byte port behind the serial bus
  input wire logic ptr_load,
  input wire logic [7:0] ptr_value,
  input wire logic byte_wr,
  input wire logic [7:0] byte_wdata,
  input wire logic byte_rd,
  input wire logic xfer_end,
  output logic [7:0] rd_byte,
  output logic rd_valid,
  // Converter side
  input wire logic [SMP_W-1:0] sample_code,
  output logic meas_active,
  output logic [1:0] meas_chan,
  output logic meas_rail
);
  mcc_state_t state_reg;
  mcc_state_t state_next;
  logic [15:0] cfg_reg;
  logic [15:0] cfg_next;
  logic [15:0] drop_res_reg;
  logic [15:0] drop_res_next;
  logic [15:0] rail_res_reg;
  logic [15:0] rail_res_next;
  logic [7:0] ptr_reg;
  logic [7:0] ptr_next;
  logic wr_phase_reg;
  logic wr_phase_next;
  logic [7:0] wr_hi_reg;
  logic [7:0] wr_hi_next;
  logic byte_sel_reg;
  logic byte_sel_next;
  logic [7:0] rd_byte_reg;
  logic [7:0] rd_byte_next;
  logic rd_valid_reg;
  logic rd_valid_next;
  logic restart_reg;
  logic restart_next;
  logic [2:0] slot_reg;
  logic [2:0] slot_next;
  logic [10:0] smp_cnt_reg;
  logic [10:0] smp_cnt_next;
  logic meas_active_reg;
  logic [1:0] meas_chan_reg;
  logic meas_rail_reg;

  logic cfg_touch;
  logic commit;
  logic [15:0] wword;
  logic [15:0] rd_word;
  logic [5:0] mask;
  logic [3:0] first_pick;
  logic [3:0] next_pick;
  logic last_sample;
  logic [15:0] result;
  logic t_start;
  logic t_abort;
  logic t_done;
  logic [2:0] ct_code;
  logic [CNT_W-1:0] t_load;

  mcc_avg_if avg_bus ();

  // Next enabled slot after cur; bit 3 set when the search wrapped
  function automatic logic [3:0] pick_slot(input logic [2:0] cur, input logic [5:0] m);
    logic [3:0] r;
    r = 4'h8;
    for (int i = 5; i >= 0; i--) begin
      if (m[i] && (3'(i) > cur)) begin
        r = {1'b0, 3'(i)};
      end
    end
    if (r[3]) begin
      for (int i = 5; i >= 0; i--) begin
        if (m[i]) begin
          r = {1'b1, 3'(i)};
        end
      end
    end
    return r;
  endfunction

  // Slot = channel * 2 + kind, kind 0 drop and 1 rail
  always_comb begin
    for (int c = 0; c < 3; c++) begin
      mask[2*c] = cfg_reg[CH_ONE_BIT-c] && cfg_reg[OP_LSB+OP_DROP_BIT]; // RULE5 RULE18
      mask[2*c+1] = cfg_reg[CH_ONE_BIT-c] && cfg_reg[OP_LSB+OP_RAIL_BIT]; // RULE9
    end
  end

  assign first_pick = pick_slot(3'h7, mask);
  assign next_pick = pick_slot(slot_reg, mask);
  assign cfg_touch = byte_wr && (ptr_reg == ADDR_CFG);
  assign commit = cfg_touch && wr_phase_reg;
  assign wword = {wr_hi_reg, byte_wdata};
  assign last_sample = smp_cnt_reg ==
    ((11'h1 << AVG_SHIFT[cfg_reg[AVG_LSB+:3]]) - 11'h1); // RULE6
  // Sign extends naturally: data sits above three zero bits
  assign result = {avg_bus.mean, 3'h0}; // RULE12 RULE13 RULE14 RULE15

  // Next slot decides which time field times it
  always_comb begin
    ct_code = slot_next[0] ? cfg_reg[RAIL_CT_LSB+:3] : cfg_reg[DROP_CT_LSB+:3]; // RULE7 RULE8
    t_load = CNT_W'(CONV_CYC_P[ct_code]);
  end

  // Register byte port, high byte first
  always_comb begin
    ptr_next = ptr_reg;
    wr_phase_next = wr_phase_reg;
    wr_hi_next = wr_hi_reg;
    byte_sel_next = byte_sel_reg;
    rd_valid_next = 1'b0;
    rd_byte_next = rd_byte_reg;
    unique case (ptr_reg)
      ADDR_CFG: rd_word = cfg_reg; // RULE10
      ADDR_DROP: rd_word = drop_res_reg; // RULE11
      ADDR_RAIL: rd_word = rail_res_reg; // RULE15
      default: rd_word = 16'h0000;
    endcase
    if (ptr_load) begin
      ptr_next = ptr_value;
      wr_phase_next = 1'b0;
      byte_sel_next = 1'b0;
    end else if (byte_wr) begin
      wr_phase_next = !wr_phase_reg; // RULE17
      wr_hi_next = byte_wdata;
    end else if (byte_rd) begin // RULE1
      rd_valid_next = 1'b1;
      rd_byte_next = byte_sel_reg ? rd_word[7:0] : rd_word[15:8]; // RULE17
      byte_sel_next = !byte_sel_reg;
    end
    // A lone first byte is dropped at the end of the transfer
    if (xfer_end) begin
      wr_phase_next = 1'b0;
      byte_sel_next = 1'b0;
    end
  end

  // Sequencer, configuration and result storage
  always_comb begin
    state_next = state_reg;
    cfg_next = cfg_reg;
    drop_res_next = drop_res_reg;
    rail_res_next = rail_res_reg;
    restart_next = restart_reg;
    slot_next = slot_reg;
    smp_cnt_next = smp_cnt_reg;
    t_start = 1'b0;
    t_abort = 1'b0;
    avg_bus.clear = 1'b0;
    avg_bus.add = 1'b0;
    unique case (state_reg)
      ST_IDLE: begin
        if (restart_reg) begin
          restart_next = 1'b0;
          if (mask != 6'h00) begin
            state_next = ST_RUN; // RULE3
            slot_next = first_pick[2:0];
            smp_cnt_next = '0;
            avg_bus.clear = 1'b1;
            t_start = 1'b1;
          end
        end
      end
      ST_HALT: begin
        if (xfer_end) begin
          state_next = ST_IDLE; // RULE2
          restart_next = 1'b1; // RULE3
        end
      end
      ST_RUN: begin
        if (t_done) begin
          avg_bus.add = 1'b1;
          smp_cnt_next = smp_cnt_reg + 11'h1;
          t_start = 1'b1;
          if (last_sample) begin
            smp_cnt_next = '0;
            avg_bus.clear = 1'b1;
            if (slot_reg == 3'h0) begin
              drop_res_next = result; // RULE11
            end
            if (slot_reg == 3'h1) begin
              rail_res_next = result; // RULE15
            end
            slot_next = next_pick[2:0];
            if (next_pick[3] && !cfg_reg[OP_LSB+OP_CONT_BIT]) begin
              state_next = ST_IDLE; // RULE19
              t_start = 1'b0;
            end
          end
        end
      end
    endcase
    // Reads take no part here, so they never disturb a conversion
    if (cfg_touch) begin
      state_next = ST_HALT; // RULE2
      restart_next = 1'b0;
      t_start = 1'b0;
      t_abort = 1'b1;
      avg_bus.add = 1'b0;
    end
    if (commit) begin
      cfg_next = wword;
      cfg_next[SOFT_RST_BIT] = 1'b0; // RULE4
      if (wword[SOFT_RST_BIT]) begin
        cfg_next = CFG_RESET; // RULE4
        drop_res_next = RESULT_RESET; // RULE16
        rail_res_next = RESULT_RESET;
      end
    end
  end

  assign avg_bus.sample = sample_code;
  assign avg_bus.shift = AVG_SHIFT[cfg_reg[AVG_LSB+:3]]; // RULE6

  mcc_averager u_avg (
    .clock(clock),
    .rst(rst),
    .av(avg_bus.avg)
  );

  mcc_timer u_timer (
    .clock(clock),
    .rst(rst),
    .start(t_start),
    .abort(t_abort),
    .load(t_load),
    .done(t_done)
  );

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_reg <= ST_IDLE;
      cfg_reg <= CFG_RESET; // RULE10
      drop_res_reg <= RESULT_RESET; // RULE16
      rail_res_reg <= RESULT_RESET;
      restart_reg <= 1'b1;
      slot_reg <= 3'h0;
      smp_cnt_reg <= '0;
      ptr_reg <= ADDR_CFG;
      wr_phase_reg <= 1'b0;
      wr_hi_reg <= 8'h00;
      byte_sel_reg <= 1'b0;
      rd_byte_reg <= 8'h00;
      rd_valid_reg <= 1'b0;
      meas_active_reg <= 1'b0;
      meas_chan_reg <= 2'h0;
      meas_rail_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cfg_reg <= cfg_next;
      drop_res_reg <= drop_res_next;
      rail_res_reg <= rail_res_next;
      restart_reg <= restart_next;
      slot_reg <= slot_next;
      smp_cnt_reg <= smp_cnt_next;
      ptr_reg <= ptr_next;
      wr_phase_reg <= wr_phase_next;
      wr_hi_reg <= wr_hi_next;
      byte_sel_reg <= byte_sel_next;
      rd_byte_reg <= rd_byte_next;
      rd_valid_reg <= rd_valid_next;
      meas_active_reg <= state_next == ST_RUN;
      meas_chan_reg <= slot_next[2:1];
      meas_rail_reg <= slot_next[0];
    end
  end

  assign rd_byte = rd_byte_reg;
  assign rd_valid = rd_valid_reg;
  assign meas_active = meas_active_reg;
  assign meas_chan = meas_chan_reg;
  assign meas_rail = meas_rail_reg;

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  sequence s_write_over;
    state_reg == ST_HALT && xfer_end && !byte_wr && mask != 6'h00;
  endsequence

  chk_read_keeps_cfg: assert property ( // RULE1
    byte_rd && !byte_wr |=> cfg_reg == $past(cfg_reg))
    else $error("read changed configuration");
  chk_write_halts: assert property ( // RULE2
    cfg_touch |=> state_reg == ST_HALT && !meas_active)
    else $error("config write did not halt");
  chk_halt_holds: assert property ( // RULE2
    state_reg == ST_HALT && !xfer_end |=> state_reg == ST_HALT)
    else $error("halt left before transfer end");
  chk_fresh_start: assert property ( // RULE3
    s_write_over ##1 !byte_wr |=> state_reg == ST_RUN)
    else $error("no new conversion after write");
  chk_soft_reset: assert property ( // RULE4
    commit && wr_hi_reg[7] |=> cfg_reg == CFG_RESET && drop_res_reg == 16'h0000)
    else $error("soft reset did not restore defaults");
  chk_cfg_store: assert property ( // RULE5
    commit && !wr_hi_reg[7] |=> cfg_reg == $past(wword))
    else $error("config write not stored");
  chk_rst_bit_low: assert property (!cfg_reg[SOFT_RST_BIT]) // RULE4
    else $error("reset bit did not clear");
  chk_reserved_zero: assert property ( // RULE14
    drop_res_reg[2:0] == 3'h0 && rail_res_reg[2:0] == 3'h0)
    else $error("reserved result bits set");
  chk_single_waits: assert property ( // RULE19
    state_reg == ST_IDLE && !restart_reg && !byte_wr |=> state_reg == ST_IDLE)
    else $error("idle left without a write");
  chk_power_down: assert property ( // RULE9
    cfg_reg[1:0] == 2'h0 && state_reg == ST_IDLE && !byte_wr |=> !meas_active)
    else $error("conversion in power-down");
  chk_high_first: assert property ( // RULE17
    byte_rd && !byte_sel_reg && !ptr_load && ptr_reg == ADDR_DROP
    |=> rd_valid && rd_byte == $past(drop_res_reg[15:8]))
    else $error("high byte not sent first");
endmodule

/* tb/mcc_host_model.sv */
// Host-side byte port driver standing in for the serial bus controller
`timescale 1ns/1ps
module mcc_host_model (
  // Clock
  input wire logic clock,
  // Register byte port
  output logic ptr_load,
  output logic [7:0] ptr_value,
  output logic byte_wr,
  output logic [7:0] byte_wdata,
  output logic byte_rd,
  output logic xfer_end,
  input wire logic [7:0] rd_byte,
  input wire logic rd_valid,
  // Conversion activity seen between the two written bytes
  input wire logic busy_probe
);
  logic busy_mid;

  initial begin
    ptr_load = 1'b0;
    ptr_value = 8'h00;
    byte_wr = 1'b0;
    byte_wdata = 8'h00;
    byte_rd = 1'b0;
    xfer_end = 1'b0;
    busy_mid = 1'b0;
  end

  task automatic step();
    @(posedge clock);
    #1;
  endtask

  // Released qualifiers show the inverse, never the stale value
  task automatic point(input logic [7:0] p);
    step();
    ptr_load = 1'b1;
    ptr_value = p;
    step();
    ptr_load = 1'b0;
    ptr_value = ~p;
  endtask

  task automatic wr_word(input logic [7:0] p, input logic [15:0] w);
    point(p);
    byte_wr = 1'b1;
    byte_wdata = w[15:8];
    step();
    busy_mid = busy_probe;
    byte_wdata = w[7:0];
    step();
    byte_wr = 1'b0;
    byte_wdata = ~w[7:0];
    xfer_end = 1'b1;
    step();
    xfer_end = 1'b0;
  endtask

  task automatic rd_word(input logic [7:0] p, output logic [15:0] w);
    point(p);
    byte_rd = 1'b1;
    step();
    w[15:8] = (rd_valid === 1'b1) ? rd_byte : 8'hxx;
    step();
    byte_rd = 1'b0;
    w[7:0] = (rd_valid === 1'b1) ? rd_byte : 8'hxx;
    xfer_end = 1'b1;
    step();
    xfer_end = 1'b0;
  endtask
endmodule

/* tb/testbench.sv */
// Self-checking bench for the conversion control block
`timescale 1ns/1ps
module testbench;
  import mcc_pkg::*;
  localparam int unsigned CC [8] = '{4, 5, 6, 7, 8, 9, 10, 11};
  logic clock;
  logic rst;
  logic ptr_load;
  logic [7:0] ptr_value;
  logic byte_wr;
  logic [7:0] byte_wdata;
  logic byte_rd;
  logic xfer_end;
  logic [7:0] rd_byte;
  logic rd_valid;
  logic [SMP_W-1:0] sample_code;
  logic meas_active;
  logic [1:0] meas_chan;
  logic meas_rail;
  logic [SMP_W-1:0] drop_v;
  logic [SMP_W-1:0] rail_v;
  logic [15:0] got;
  int err_total;
  int checked;
  int cycles;
  int hi_a;
  int hi_b;
  int cfg_m;
  int drop_m;
  int rail_m;
  int nk;
  int md [4] = '{3, 1, 2, 3};

  mcc_monitor_core #(.CONV_CYC_P(CC)) u_dut (
    .clock(clock),
    .rst(rst),
    .ptr_load(ptr_load),
    .ptr_value(ptr_value),
    .byte_wr(byte_wr),
    .byte_wdata(byte_wdata),
    .byte_rd(byte_rd),
    .xfer_end(xfer_end),
    .rd_byte(rd_byte),
    .rd_valid(rd_valid),
    .sample_code(sample_code),
    .meas_active(meas_active),
    .meas_chan(meas_chan),
    .meas_rail(meas_rail)
  );

  mcc_host_model u_host (
    .clock(clock),
    .ptr_load(ptr_load),
    .ptr_value(ptr_value),
    .byte_wr(byte_wr),
    .byte_wdata(byte_wdata),
    .byte_rd(byte_rd),
    .xfer_end(xfer_end),
    .rd_byte(rd_byte),
    .rd_valid(rd_valid),
    .busy_probe(meas_active)
  );

  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  // Converter stand-in: one fixed code per kind for each pass of the loop
  always @(posedge clock) begin
    sample_code <= #1 (meas_rail ? rail_v : drop_v);
  end

  task automatic conclude();
    if (err_total == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  always @(posedge clock) begin
    cycles++;
    if (cycles == 30000) begin
      err_total++;
      conclude();
    end
  end

  task automatic chk(input string name, input int exp, input logic [15:0] seen);
    checked++;
    if (seen !== exp[15:0]) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", name, exp[15:0], seen);
    end
  endtask

  // Model of the configuration word and soft reset
  task automatic cfg_wr(input int w);
    u_host.wr_word(ADDR_CFG, w[15:0]);
    if (w[15]) begin
      cfg_m = 32'h7127;
      drop_m = 0;
      rail_m = 0;
    end else begin
      cfg_m = w;
    end
  endtask

  task automatic rd_chk(input logic [7:0] p, input int exp, input string name);
    u_host.rd_word(p, got);
    chk(name, exp, got);
  endtask

  // Counts active cycles until 30 quiet cycles in a row
  task automatic wait_idle(output int hi);
    int q;
    q = 0;
    hi = 0;
    for (int n = 0; n < 3000 && q < 30; n++) begin
      u_host.step();
      if (meas_active === 1'b1) begin
        hi++;
        q = 0;
      end else begin
        q++;
      end
    end
    chk("idle reached", 1, {15'h0000, q >= 30});
  endtask

  initial begin
    void'($urandom(7));
    rst = 1'b1;
    drop_v = '0;
    rail_v = '0;
    err_total = 0;
    checked = 0;
    cycles = 0;
    cfg_m = 32'h7127;
    drop_m = 0;
    rail_m = 0;
    repeat (16) @(posedge clock);
    #1;
    rst = 1'b0;
    rd_chk(ADDR_CFG, cfg_m, "config");
    rd_chk(ADDR_DROP, 0, "drop");
    rd_chk(ADDR_RAIL, 0, "rail");
    rd_chk(8'h05, 0, "unmapped");
    rd_chk(ADDR_CFG, cfg_m, "config reread");
    for (int i = 0; i < 4; i++) begin
      drop_v = 13'($urandom());
      rail_v = 13'($urandom());
      drop_v[12] = i[0];
      // Full scale on a kind that this pass converts
      if (i == 0) begin
        drop_v = 13'h0fff;
      end
      if (i == 2) begin
        rail_v = 13'h0fff;
      end
      cfg_wr(32'h4000 | (i << 9) | md[i]);
      chk("halt on write", 0, {15'h0000, u_host.busy_mid});
      wait_idle(hi_a);
      nk = (md[i] & 1) + (md[i] >> 1);
      chk("avg span", nk * (1 << (2 * i)) * CC[0], 16'(hi_a));
      if (md[i] & 1) begin
        drop_m = {drop_v, 3'b000};
      end
      if (md[i] & 2) begin
        rail_m = {rail_v, 3'b000};
      end
      rd_chk(ADDR_DROP, drop_m, "drop");
      rd_chk(ADDR_RAIL, rail_m, "rail");
      chk("single idle", 0, {15'h0000, meas_active});
      rd_chk(ADDR_CFG, cfg_m, "config");
    end
    u_host.wr_word(ADDR_DROP, 16'hffff);
    rd_chk(ADDR_DROP, drop_m, "drop read only");
    for (int r = 0; r < 2; r++) begin
      cfg_wr(r ? 32'h4002 : 32'h4001);
      wait_idle(hi_a);
      cfg_wr(r ? 32'h41c2 : 32'h4039);
      wait_idle(hi_b);
      chk("conv span", CC[7] - CC[0], 16'(hi_b - hi_a));
    end
    for (int m = 0; m < 8; m++) begin
      cfg_wr(32'h7000 | m);
      u_host.step();
      u_host.step();
      chk("active", (m % 4) != 0, {15'h0000, meas_active});
      if ((m % 4) != 0) begin
        chk("kind", (m % 4) == 2, {15'h0000, meas_rail});
      end
    end
    for (int k = 0; k < 3; k++) begin
      cfg_wr((32'h1000 << k) | 7);
      u_host.step();
      u_host.step();
      chk("channel", 2 - k, {14'h0000, meas_chan});
    end
    cfg_wr(32'h0007);
    u_host.step();
    u_host.step();
    chk("none enabled", 0, {15'h0000, meas_active});
    cfg_wr(32'h8203);
    rd_chk(ADDR_DROP, drop_m, "drop after soft reset");
    rd_chk(ADDR_RAIL, rail_m, "rail after soft reset");
    rd_chk(ADDR_CFG, cfg_m, "config after soft reset");
    conclude();
  end
endmodule
